// [rtl/cll_pkg.sv]
`default_nettype none
package cll_pkg;
  // core population and widths
  localparam int NUM_CORES  = 8;
  localparam int CORE_IDX_W = 3;
  localparam int REQ_IDX_W  = 4;
  localparam int ADDR_W     = 16;
  localparam int WORD_W     = 32;
  localparam int CRAM_W     = 9;

  // image lengths in longs
  localparam logic [CRAM_W-1:0] MACHINE_LONGS = 9'd496;
  localparam logic [CRAM_W-1:0] INTERP_LONGS  = 9'd496;
  localparam logic [1:0]        FRAME_LONGS   = 2'd2;

  // interpreter image location in main ROM
  localparam logic [ADDR_W-1:0] INTERP_ROM_BASE = 16'hf004;

  // boot parameter field: bits 2 through 15 pass, bits 1:0 read zero
  localparam int PARAM_LSB = 2;
  localparam int PARAM_MSB = 15;

  // core 0 runs out of reset so that someone can issue requests
  localparam logic [NUM_CORES-1:0] RUN_RESET = 8'h01;

  // result reported when no core was free
  localparam logic [REQ_IDX_W-1:0] RESULT_FAIL = 4'hf;

  typedef enum logic [1:0] {
    CLL_TARGETED,
    CLL_NEXT,
    CLL_STOP
  } cll_kind_e;

  typedef enum logic {
    CLL_INTERP,
    CLL_MACHINE
  } cll_code_e;

  typedef struct packed {
    cll_kind_e             kind;
    cll_code_e             code;
    logic [REQ_IDX_W-1:0]  core_idx;
    logic [ADDR_W-1:0]     code_addr;  // machine_code_address or entry
    logic [ADDR_W-1:0]     param;      // parameter or stack_region_pointer
  } cll_req_s;

  typedef struct packed {
    logic                  valid;
    logic [REQ_IDX_W-1:0]  value;      // 0..7, or all ones for -1
  } cll_result_s;
endpackage : cll_pkg
`default_nettype wire

// [rtl/cll_free_pick.sv]
`default_nettype none
module cll_free_pick
  import cll_pkg::*;
#(
  parameter int N = NUM_CORES
) (
  // core occupancy
  input  wire logic [N-1:0]          busy,
  // lowest free core
  output logic                       found,
  output logic [CORE_IDX_W-1:0]      idx
);
  always_comb begin
    found = 1'b0;
    idx   = '0;
    for (int i = N - 1; i >= 0; i--) begin
      if (!busy[i]) begin
        found = 1'b1;
        idx   = CORE_IDX_W'(i);
      end
    end
  end
endmodule : cll_free_pick
`default_nettype wire

// [rtl/cll_launch.sv]
// Operation
// - targeted launch starts named core, no result
// - targeted launch on running core restarts it
// - interpreted launch writes stack frame before start
// - boot parameter keeps bits 2-15, low zero
// - boot parameter read-only to the core
// - next-available launch returns index or minus one
// - interpreted launch loads interpreter from ROM
// - machine launch copies program from main RAM
// - requester and new core run independently
// - targeted index 8-15 acts as next-available
// - copy 496 longs, set parameter, clear specials
// - stop clears the core's run bit
`default_nettype none
module cll_launch
  import cll_pkg::*;
(
  // clock and reset
  input  wire logic                         clock,
  input  wire logic                         rst,
  // requests from the cores
  input  wire logic                         req_valid,
  input  wire cll_pkg::cll_req_s            req,
  output logic                              req_ready,
  output logic                              done,
  output cll_pkg::cll_result_s              result,
  // main memory port, read data one cycle after mem_rd_en
  output logic                              mem_rd_en,
  output logic [cll_pkg::ADDR_W-1:0]        mem_rd_addr,
  input  wire logic [cll_pkg::WORD_W-1:0]   mem_rd_data,
  output logic                              mem_wr_en,
  output logic [cll_pkg::ADDR_W-1:0]        mem_wr_addr,
  output logic [cll_pkg::WORD_W-1:0]        mem_wr_data,
  // core RAM loader
  output logic                              cram_wr_en,
  output logic [cll_pkg::CORE_IDX_W-1:0]    cram_wr_core,
  output logic [cll_pkg::CRAM_W-1:0]        cram_wr_addr,
  output logic [cll_pkg::WORD_W-1:0]        cram_wr_data,
  // per-core control
  output logic [cll_pkg::NUM_CORES-1:0]     core_run,
  output logic [cll_pkg::NUM_CORES-1:0]     core_clear,
  output logic [cll_pkg::NUM_CORES-1:0][cll_pkg::ADDR_W-1:0]
                                            boot_parameter_register
);
  import cll_pkg::*;

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_FRAME,
    ST_COPY,
    ST_DRAIN,
    ST_START
  } cll_state_e;

  cll_state_e            state;
  logic [CORE_IDX_W-1:0] target;
  cll_code_e             code;
  logic [ADDR_W-1:0]     src_base;
  logic [ADDR_W-1:0]     entry;
  logic [ADDR_W-1:0]     stack_ptr;
  logic [CRAM_W-1:0]     count;
  logic [CRAM_W-1:0]     length;
  logic [CRAM_W-1:0]     rd_idx;
  logic [CRAM_W-1:0]     pend_idx;
  logic                  rd_pend;
  logic [1:0]            frame_idx;
  logic                  next_pending;

  logic                  free_found;
  logic [CORE_IDX_W-1:0] free_idx;
  logic                  accept;
  logic                  want_next;
  logic                  go;
  logic [CORE_IDX_W-1:0] go_core;
  logic [ADDR_W-1:0]     aligned_param;

  cll_free_pick #(.N(NUM_CORES)) u_pick (
    .busy  (core_run),
    .found (free_found),
    .idx   (free_idx)
  );

  assign accept    = req_valid && req_ready;
  // an out-of-range index falls back to the free-core search
  assign want_next = (req.kind == CLL_NEXT) ||
                     (req.kind == CLL_TARGETED &&
                      req.core_idx[REQ_IDX_W-1]);
  assign go        = accept && req.kind != CLL_STOP &&
                     (!want_next || free_found);
  assign go_core   = want_next ? free_idx
                               : req.core_idx[CORE_IDX_W-1:0];
  assign aligned_param = {req.param[PARAM_MSB:PARAM_LSB],
                          {PARAM_LSB{1'b0}}};

  // sequencer: one request at a time, the block holds req_ready low while busy
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      state     <= ST_IDLE;
      req_ready <= 1'b1;
      target    <= '0;
      code      <= CLL_MACHINE;
      src_base  <= '0;
      entry     <= '0;
      stack_ptr <= '0;
      length    <= '0;
      count     <= '0;
      frame_idx <= '0;
    end else begin
      case (state)
        ST_IDLE: begin
          if (go) begin
            req_ready <= 1'b0;
            target    <= go_core;
            code      <= req.code;
            entry     <= req.code_addr;
            stack_ptr <= aligned_param;
            count     <= '0;
            frame_idx <= '0;
            if (req.code == CLL_INTERP) begin
              src_base <= INTERP_ROM_BASE;
              length   <= INTERP_LONGS;
              state    <= ST_FRAME;
            end else begin
              src_base <= req.code_addr;
              length   <= MACHINE_LONGS;
              state    <= ST_COPY;
            end
          end
        end
        ST_FRAME: begin
          if (frame_idx == FRAME_LONGS - 2'd1) begin
            state <= ST_COPY;
          end
          frame_idx <= frame_idx + 2'd1;
        end
        ST_COPY: begin
          if (count == length - 9'd1) begin
            state <= ST_DRAIN;
          end
          count <= count + 9'd1;
        end
        ST_DRAIN: begin
          if (!mem_rd_en && !rd_pend) begin
            state <= ST_START;
          end
        end
        ST_START: begin
          state     <= ST_IDLE;
          req_ready <= 1'b1;
        end
        default: state <= ST_IDLE;
      endcase
    end
  end

  // stack frame into main RAM, finished before the core is released
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      mem_wr_en   <= 1'b0;
      mem_wr_addr <= '0;
      mem_wr_data <= '0;
    end else begin
      mem_wr_en <= (state == ST_FRAME);
      if (state == ST_FRAME) begin
        mem_wr_addr <= stack_ptr + ADDR_W'({frame_idx, 2'b00});
        mem_wr_data <= (frame_idx == 2'd0) ? WORD_W'(entry) : '0;
      end
    end
  end

  // image copy: read issue, then write one cycle after the data returns
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      mem_rd_en    <= 1'b0;
      mem_rd_addr  <= '0;
      rd_idx       <= '0;
      rd_pend      <= 1'b0;
      pend_idx     <= '0;
      cram_wr_en   <= 1'b0;
      cram_wr_core <= '0;
      cram_wr_addr <= '0;
      cram_wr_data <= '0;
    end else begin
      mem_rd_en <= (state == ST_COPY);
      if (state == ST_COPY) begin
        mem_rd_addr <= src_base + ADDR_W'({count, 2'b00});
        rd_idx      <= count;
      end
      rd_pend    <= mem_rd_en;
      pend_idx   <= rd_idx;
      cram_wr_en <= rd_pend;
      if (rd_pend) begin
        cram_wr_core <= target;
        cram_wr_addr <= pend_idx;
        cram_wr_data <= mem_rd_data;
      end
    end
  end

  // core run state; only the target changes so others keep going
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      core_run <= RUN_RESET;
    end else begin
      if (accept && req.kind == CLL_STOP && !req.core_idx[REQ_IDX_W-1]) begin
        core_run[req.core_idx[CORE_IDX_W-1:0]] <= 1'b0;
      end else if (go) begin
        // a running target, even the requester, is halted while reloaded
        core_run[go_core] <= 1'b0;
      end else if (state == ST_START) begin
        core_run[target] <= 1'b1;
      end
    end
  end

  // boot parameter and special-register clear, written only here
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      boot_parameter_register <= '0;
      core_clear              <= '0;
    end else begin
      core_clear <= '0;
      if (state == ST_START) begin
        boot_parameter_register[target] <= stack_ptr;
        core_clear[target]              <= 1'b1;
      end
    end
  end

  // completion and result
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      done   <= 1'b0;
      result <= '0;
    end else begin
      done         <= 1'b0;
      result.valid <= 1'b0;
      if (accept && req.kind == CLL_STOP) begin
        done <= 1'b1;
      end else if (accept && want_next && !free_found) begin
        done         <= 1'b1;
        result.valid <= 1'b1;
        result.value <= RESULT_FAIL;
      end else if (state == ST_START) begin
        done <= 1'b1;
        // only a next-available launch reports its index
        if (next_pending) begin
          result.value <= REQ_IDX_W'(target);
        end
      end
      if (go) begin
        // targeted launches report nothing
        result.valid <= 1'b0;
      end
    end
  end

  // remembers that the launch under way must report its core index
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      next_pending <= 1'b0;
    end else if (go) begin
      next_pending <= want_next;
    end else if (state == ST_START) begin
      next_pending <= 1'b0;
    end
  end
endmodule : cll_launch
`default_nettype wire

// [bench/cll_mem_model.sv]
`default_nettype none
module cll_mem_model
  import cll_pkg::*;
(
  // main memory read port
  input  wire logic              clock,
  input  wire logic              rd_en,
  input  wire logic [ADDR_W-1:0] rd_addr,
  output logic      [WORD_W-1:0] rd_data
);
  timeunit 1ns;
  timeprecision 1ns;
  initial rd_data = '0;
  // data is good one cycle after a read only; otherwise it is scrambled
  always @(posedge clock) begin
    rd_data <= rd_en ? {rd_addr, ~rd_addr} : ~rd_data;
  end
endmodule : cll_mem_model
`default_nettype wire

// [bench/cll_launch_properties.sv]
`default_nettype none
module cll_launch_checker
  import cll_pkg::*;
(
  // clock and reset
  input wire logic                              clock,
  input wire logic                              rst,
  // requests
  input wire logic                              req_valid,
  input wire cll_req_s                          req,
  input wire logic                              req_ready,
  input wire logic                              done,
  input wire cll_result_s                       result,
  // cores
  input wire logic                              cram_wr_en,
  input wire logic [CRAM_W-1:0]                 cram_wr_addr,
  input wire logic [NUM_CORES-1:0]              core_run,
  input wire logic [NUM_CORES-1:0]              core_clear,
  input wire logic [NUM_CORES-1:0][ADDR_W-1:0]  boot_parameter_register
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge clock);
  endclocking
  default disable iff (rst);
  logic take;
  logic low_bits;
  logic [2:0] idx;
  assign take = req_valid && req_ready;
  assign idx = req.core_idx[2:0];
  always_comb begin
    low_bits = 1'b0;
    for (int i = 0; i < NUM_CORES; i++)
      low_bits = low_bits | (|boot_parameter_register[i][1:0]);
  end
  a_param_aligned:
    assert property (!low_bits) else $error("param low bits set");
  a_param_readonly:
    assert property (!$stable(boot_parameter_register) |-> |core_clear)
    else $error("param changed outside start");
  a_stop_dormant:
    assert property (take && req.kind == CLL_STOP && !req.core_idx[3]
      |=> done && !core_run[$past(idx)]) else $error("stop failed");
  a_launch_bound:
    assert property (take && req.kind == CLL_TARGETED && !req.core_idx[3]
      |=> !req_ready ##[0:600] done) else $error("launch too slow");
  a_fail_report:
    assert property (take && req.kind == CLL_NEXT && &core_run
      |=> done && result.value == RESULT_FAIL && $stable(core_run))
    else $error("bad fail report");
  a_target_halt:
    assert property (take && req.kind == CLL_TARGETED && !req.core_idx[3]
      |=> !core_run[$past(idx)]) else $error("target not halted");
  a_start_clear:
    assert property (|core_clear |-> done && (core_run & core_clear) ==
      core_clear) else $error("clear without start");
  a_cram_range:
    assert property (cram_wr_en |-> cram_wr_addr < MACHINE_LONGS)
    else $error("core ram address out of range");
  c_fail: cover property (result.valid);
  c_stop: cover property (take && req.kind == CLL_STOP);
  c_self: cover property (take && req.core_idx == 4'h0 && core_run[0]);
endmodule : cll_launch_checker
bind cll_launch cll_launch_checker u_cll_launch_checker (
  .clock(clock), .rst(rst), .req_valid(req_valid), .req(req),
  .req_ready(req_ready), .done(done), .result(result),
  .cram_wr_en(cram_wr_en), .cram_wr_addr(cram_wr_addr),
  .core_run(core_run), .core_clear(core_clear),
  .boot_parameter_register(boot_parameter_register));
`default_nettype wire

// [bench/tb.sv]
`default_nettype none
module tb;
  import cll_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;
  logic clock, rst, req_valid, req_ready, done, rd_en, wr_en, cw_en;
  cll_req_s req;
  cll_result_s result;
  logic [ADDR_W-1:0] rd_addr, wr_addr, src_exp, sp_exp, csrc, ent_exp;
  logic [WORD_W-1:0] rd_data, cw_data, wr_data;
  logic [CORE_IDX_W-1:0] cw_core;
  logic [CRAM_W-1:0] cw_addr;
  logic [NUM_CORES-1:0] core_run, run_exp;
  logic [NUM_CORES-1:0][ADDR_W-1:0] bpr;
  logic [REQ_IDX_W-1:0] core_exp;
  int miscompares, n_compared, n_cram, n_frame;
  bit cram_seen;
  assign csrc = src_exp + {5'h00, cw_addr, 2'b00};
  cll_launch u_cll_launch (.clock(clock), .rst(rst), .req_valid(req_valid),
    .req(req), .req_ready(req_ready), .done(done), .result(result),
    .mem_rd_en(rd_en), .mem_rd_addr(rd_addr), .mem_rd_data(rd_data),
    .mem_wr_en(wr_en), .mem_wr_addr(wr_addr), .mem_wr_data(wr_data),
    .cram_wr_en(cw_en), .cram_wr_core(cw_core), .cram_wr_addr(cw_addr),
    .cram_wr_data(cw_data), .core_run(core_run), .core_clear(),
    .boot_parameter_register(bpr));
  cll_mem_model u_cll_mem_model (.clock(clock), .rd_en(rd_en),
    .rd_addr(rd_addr), .rd_data(rd_data));
  initial begin
    clock = 1'b0;
    forever #20 clock = ~clock;
  end
  task automatic chk(input bit ok, input string msg);
    n_compared++;
    if (!ok) begin
      miscompares++;
      $display("[ERR] %0t %s", $time, msg);
    end
  endtask : chk
  task automatic end_of_test;
    $display("compared %0d miscompares %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : end_of_test
  always @(posedge clock) begin
    if (cw_en) begin
      n_cram++;
      cram_seen = 1'b1;
      chk(cw_core === core_exp[2:0] && cw_data === {csrc, ~csrc}, "cram");
    end
    if (wr_en) begin
      n_frame++;
      chk(!cram_seen && (wr_addr === sp_exp || wr_addr === sp_exp + 16'h4), "frame");
      chk(wr_data === ((wr_addr === sp_exp) ? {16'h0000, ent_exp} : 32'h0), "frame data");
    end
  end
  task automatic launch(input cll_kind_e k, input cll_code_e c,
    input logic [3:0] idx, input logic [15:0] a, p, input logic [3:0] e);
    int n;
    core_exp = e;
    src_exp = (c == CLL_INTERP) ? INTERP_ROM_BASE : a;
    ent_exp = a;
    sp_exp = p;
    n_cram = 0;
    n_frame = 0;
    cram_seen = 1'b0;
    @(posedge clock);
    req_valid <= 1'b1;
    req <= '{kind: k, code: c, core_idx: idx, code_addr: a, param: p};
    // stop and fail answer at the take edge itself, so look right after it
    @(posedge clock);
    req_valid <= 1'b0;
    #1 n = 0;
    while (done !== 1'b1 && n < 1000) begin
      @(posedge clock);
      #1 n++;
    end
    chk(n < 1000 && req_ready === 1'b1, "no done");
    if (k == CLL_STOP) begin
      if (!idx[3]) run_exp[idx[2:0]] = 1'b0;
    end else if (e == RESULT_FAIL) begin
      chk(result.valid === 1'b1 && result.value === e && n_cram == 0, "fail");
    end else begin
      run_exp[e[2:0]] = 1'b1;
      chk(n_cram == 496 && n_frame == (c == CLL_INTERP ? 2 : 0), "length");
      chk(bpr[e[2:0]] === {p[15:2], 2'b00}, "boot parameter");
      if (k == CLL_NEXT) chk(result.value === e, "index");
    end
    chk(core_run === run_exp, "run state");
  endtask : launch
  task automatic t_targeted;
    launch(CLL_TARGETED, CLL_MACHINE, 4'd2, 16'h2000, 16'h1237, 4'd2);
  endtask : t_targeted
  task automatic t_next_interp;
    // each interpreted core gets its own stack
    launch(CLL_NEXT, CLL_INTERP, 4'd0, 16'h0abc, 16'h0100, 4'd1);
  endtask : t_next_interp
  task automatic t_wide_index;
    // value 16 passed shifted left two
    launch(CLL_TARGETED, CLL_MACHINE, 4'd9, 16'h3000, 16'h0040, 4'd3);
  endtask : t_wide_index
  task automatic t_restart;
    launch(CLL_TARGETED, CLL_MACHINE, 4'd2, 16'h4000, 16'h0000, 4'd2);
    launch(CLL_TARGETED, CLL_MACHINE, 4'd0, 16'h5000, 16'h0008, 4'd0);
  endtask : t_restart
  task automatic t_stop_relaunch;
    // stop first so the reused stack is not clobbered
    launch(CLL_STOP, CLL_MACHINE, 4'd1, 16'h0, 16'h0, 4'd1);
    launch(CLL_TARGETED, CLL_INTERP, 4'd1, 16'h0abc, 16'h0100, 4'd1);
  endtask : t_stop_relaunch
  task automatic t_exhaust;
    for (int i = 4; i < 8; i++)
      launch(CLL_NEXT, CLL_MACHINE, 4'd0, 16'h6000, 16'(i * 16), 4'(i));
    launch(CLL_NEXT, CLL_MACHINE, 4'd0, 16'h6000, 16'h0, RESULT_FAIL);
    launch(CLL_TARGETED, CLL_MACHINE, 4'd10, 16'h6000, 16'h0, RESULT_FAIL);
  endtask : t_exhaust
  task automatic t_stops;
    launch(CLL_STOP, CLL_MACHINE, 4'd3, 16'h0, 16'h0, 4'd3);
    launch(CLL_STOP, CLL_MACHINE, 4'd12, 16'h0, 16'h0, 4'd0);
  endtask : t_stops
  initial begin
    #(40 * 20000);
    miscompares++;
    end_of_test();
  end
  initial begin
    rst = 1'b1;
    req_valid = 1'b0;
    req = '0;
    run_exp = RUN_RESET;
    repeat (8) @(posedge clock);
    rst <= 1'b0;
    @(posedge clock);
    #1 chk(core_run === RUN_RESET && req_ready === 1'b1, "reset");
    t_targeted();
    t_next_interp();
    t_wide_index();
    t_restart();
    t_stop_relaunch();
    t_exhaust();
    t_stops();
    end_of_test();
  end
endmodule : tb
`default_nettype wire
